// ---- rtl/cbaac_top.sv ----
/*
 * APB register file, acquisition sequencer, result packing and pin
 * control for cell, stack and auxiliary measurements.
 * Assumes a conversion engine on mclk that answers each start with one
 * done pulse, and an asynchronous supply mux fault pin.
 */
`timescale 1ns/10ps
module cbaac_top
    import cbaac_pkg::*;
#(
    parameter int OVS = OVS_COUNT
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion engine.
    output logic conv_start,
    output logic [4:0] conv_channel,
    output logic conv_alt_path,
    output logic conv_bipolar,
    output logic conv_ratiometric,
    input wire logic conv_done,
    input wire logic [CODE_W-1:0] conv_code,
    // Analog switch and pin control.
    output logic stack_divider_close,
    output logic bias_output_pin_en,
    output logic [N_AUX-1:0] aux_io_mode,
    output logic [3:0] supply_input_mux_sel,
    output logic supply_input_mux_en,
    output logic [3:0] top_block_sel,
    output logic acq_busy,
    // Supply mux fault.
    input wire logic supply_mux_fault_raw,
    output logic supply_mux_fault_alert
);
    typedef enum logic [1:0] {S_IDLE, S_SEEK, S_REQ, S_WAIT} cbaac_state_e;

    logic [N_CELL-1:0] cell_channel_enable_q;
    logic stack_voltage_enable_q;
    logic [N_AUX-1:0] aux_measure_enable_q;
    logic input_path_select_q;
    logic [N_CELL-1:0] polarity_q;
    logic [N_AUX-1:0] aux_reference_select_q;
    logic [N_AUX-1:0] port_io_override_q;
    logic [1:0] bias_output_mode_q;
    logic [3:0] top_cell_select_q;
    logic flex_pack_enable_q;
    logic [3:0] top_block_select_q;
    logic alert_reset_flag_q;
    logic fault_meta_q;
    logic fault_sync_q;
    logic alert_q;
    logic [RES_W-1:0] result_q [0:N_CHAN-1];
    cbaac_state_e state_q;
    logic [4:0] chan_q;
    logic [2:0] ovs_cnt_q;
    logic [RES_W-1:0] acc_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic conv_alt_q;
    logic conv_bipolar_q;
    logic conv_ratio_q;

    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire [7:0] res_off = paddr - ADDR_RESULT0;
    wire [4:0] res_idx = res_off[6:2];
    wire is_result = paddr >= ADDR_RESULT0 && paddr <= ADDR_RESULT_LAST && paddr[1:0] == 2'h0;
    wire [N_AUX-1:0] aux_active = aux_measure_enable_q & ~port_io_override_q;
    wire [N_CHAN-1:0] chan_en = {aux_active, stack_voltage_enable_q, cell_channel_enable_q};
    wire [N_CHAN-1:0] chan_alt;
    wire [N_CHAN-1:0] chan_bipolar;
    wire [N_CHAN-1:0] chan_ratio;
    wire last_chan = chan_q == 5'(N_CHAN - 1);
    wire scan_go = wr_en && paddr == ADDR_SCAN && pwdata[SCAN_START_BIT] && state_q == S_IDLE;
    wire [RES_W-1:0] code_ext = conv_bipolar ? {{(RES_W-CODE_W){conv_code[CODE_W-1]}}, conv_code}
                                              : {{(RES_W-CODE_W){1'b0}}, conv_code};
    wire [RES_W-1:0] acc_next = acc_q + code_ext;
    wire last_ovs = ovs_cnt_q == 3'(OVS - 1);
    wire top_cell_bad = top_cell_select_q <= TOP_CELL_MAX_BAD || top_cell_select_q == TOP_POS_DEFAULT;
    wire top_block_bad = top_block_select_q <= TOP_CELL_MAX_BAD;

    // Register reads are captured in the setup phase and answered at once.
    logic [31:0] rd_mux;
    logic rd_bad;
    always_comb begin
        rd_mux = 32'h0;
        rd_bad = 1'b0;
        if (is_result) begin
            rd_mux = {16'h0, result_q[res_idx], 2'h0};
        end else begin
            unique case (paddr)
                ADDR_MEAS_A: rd_mux = {17'h0, stack_voltage_enable_q, cell_channel_enable_q};
                ADDR_MEAS_B: rd_mux = {26'h0, aux_measure_enable_q};
                ADDR_SCAN: rd_mux = {29'h0, acq_busy, input_path_select_q, 1'b0};
                ADDR_POLARITY: rd_mux = {18'h0, polarity_q};
                ADDR_AUX_REF: rd_mux = {26'h0, aux_reference_select_q};
                ADDR_AUX_PORT: rd_mux = {26'h0, port_io_override_q};
                ADDR_ACQ_CFG: rd_mux = {30'h0, bias_output_mode_q};
                ADDR_PACK: rd_mux = {20'h0, top_block_select_q, 3'h0, flex_pack_enable_q,
                                     top_cell_select_q};
                ADDR_STATUS: rd_mux = {30'h0, alert_reset_flag_q, alert_q};
                default: rd_bad = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
            pslverr_q <= rd_bad;
        end
    end

    assign prdata = prdata_q;
    assign pready = psel && penable;
    assign pslverr = psel && penable && pslverr_q;

    // Configuration registers.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cell_channel_enable_q <= '0;
            stack_voltage_enable_q <= 1'b0;
            aux_measure_enable_q <= '0;
            input_path_select_q <= 1'b0;
            polarity_q <= '0;
            aux_reference_select_q <= '0;
            port_io_override_q <= '0;
            bias_output_mode_q <= BIAS_MODE_RESET;
            top_cell_select_q <= TOP_CELL_OFF;
            flex_pack_enable_q <= 1'b1;
            top_block_select_q <= TOP_POS_DEFAULT;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_MEAS_A: begin
                    cell_channel_enable_q <= pwdata[N_CELL-1:0];
                    stack_voltage_enable_q <= pwdata[MEAS_A_STACK_BIT];
                end
                ADDR_MEAS_B: aux_measure_enable_q <= pwdata[N_AUX-1:0];
                ADDR_SCAN: input_path_select_q <= pwdata[SCAN_PATH_BIT];
                ADDR_POLARITY: polarity_q <= pwdata[N_CELL-1:0];
                ADDR_AUX_REF: aux_reference_select_q <= pwdata[N_AUX-1:0];
                ADDR_AUX_PORT: port_io_override_q <= pwdata[N_AUX-1:0];
                ADDR_ACQ_CFG: bias_output_mode_q <= pwdata[1:0];
                ADDR_PACK: begin
                    top_cell_select_q <= pwdata[3:0];
                    flex_pack_enable_q <= pwdata[PACK_FLEX_BIT];
                    top_block_select_q <= pwdata[PACK_BLOCK_LSB+3:PACK_BLOCK_LSB];
                end
                default: ;
            endcase
        end
    end

    // Fault pin synchroniser, power-up alert gate and alert output.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_meta_q <= 1'b0;
            fault_sync_q <= 1'b0;
            alert_reset_flag_q <= 1'b1;
            alert_q <= 1'b0;
        end else begin
            fault_meta_q <= supply_mux_fault_raw;
            fault_sync_q <= fault_meta_q;
            if (wr_en && paddr == ADDR_STATUS && pwdata[STATUS_RST_FLAG_BIT]) begin
                alert_reset_flag_q <= 1'b0;
            end
            alert_q <= fault_sync_q && !alert_reset_flag_q && supply_input_mux_en;
        end
    end

    assign supply_mux_fault_alert = alert_q;

    // Acquisition sequencer: seek enabled channels, oversample, store.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            chan_q <= 5'h0;
            ovs_cnt_q <= 3'h0;
            acc_q <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (scan_go) begin
                        state_q <= S_SEEK;
                        chan_q <= 5'h0;
                    end
                end
                S_SEEK: begin
                    if (chan_en[chan_q]) begin
                        state_q <= S_REQ;
                        ovs_cnt_q <= 3'h0;
                        acc_q <= '0;
                    end else if (last_chan) begin
                        state_q <= S_IDLE;
                    end else begin
                        chan_q <= chan_q + 5'h1;
                    end
                end
                S_REQ: state_q <= S_WAIT;
                S_WAIT: begin
                    if (conv_done) begin
                        acc_q <= acc_next;
                        ovs_cnt_q <= ovs_cnt_q + 3'h1;
                        if (!last_ovs) begin
                            state_q <= S_REQ;
                        end else if (last_chan) begin
                            state_q <= S_IDLE;
                        end else begin
                            state_q <= S_SEEK;
                            chan_q <= chan_q + 5'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Per-channel conversion attributes and result words.
    genvar gi;
    generate
        for (gi = 0; gi < N_CHAN; gi++) begin : g_res
            if (gi < N_CELL) begin : g_cell
                assign chan_alt[gi] = input_path_select_q;
                assign chan_bipolar[gi] = polarity_q[gi];
                assign chan_ratio[gi] = 1'b0;
            end else if (gi == STACK_IDX) begin : g_stack
                assign chan_alt[gi] = 1'b0;
                assign chan_bipolar[gi] = 1'b0;
                assign chan_ratio[gi] = 1'b0;
            end else begin : g_aux
                assign chan_alt[gi] = 1'b0;
                assign chan_bipolar[gi] = 1'b0;
                assign chan_ratio[gi] = aux_reference_select_q[gi-N_CELL-1];
            end
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    result_q[gi] <= '0;
                end else if (state_q == S_WAIT && conv_done && last_ovs && chan_q == 5'(gi)) begin
                    result_q[gi] <= acc_next;
                end
            end
        end
    endgenerate

    // Request flags are frozen while a channel is chosen, so a register write
    // during a conversion cannot change them before the engine answers.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            conv_alt_q <= 1'b0;
            conv_bipolar_q <= 1'b0;
            conv_ratio_q <= 1'b0;
        end else if (state_q == S_SEEK) begin
            conv_alt_q <= chan_alt[chan_q];
            conv_bipolar_q <= chan_bipolar[chan_q];
            conv_ratio_q <= chan_ratio[chan_q];
        end
    end

    assign acq_busy = state_q != S_IDLE;
    assign conv_start = state_q == S_REQ;
    assign conv_channel = chan_q;
    assign conv_alt_path = conv_alt_q;
    assign conv_bipolar = conv_bipolar_q;
    assign conv_ratiometric = conv_ratio_q;
    assign stack_divider_close = acq_busy && stack_voltage_enable_q;
    assign bias_output_pin_en = bias_output_mode_q == BIAS_MODE_ON
                             || (!bias_output_mode_q[1] && acq_busy);
    assign aux_io_mode = port_io_override_q;
    assign supply_input_mux_sel = top_cell_bad ? TOP_CELL_OFF : top_cell_select_q;
    assign supply_input_mux_en = flex_pack_enable_q && !top_cell_bad;
    assign top_block_sel = top_block_bad ? TOP_POS_DEFAULT : top_block_select_q;
endmodule : cbaac_top

// ---- rtl/cbaac_pkg.sv ----
/*
 * Constants, register map and field positions for the cell, stack and
 * auxiliary acquisition configuration block.
 * Assumes a 32-bit APB master and a same-clock conversion engine.
 */
package cbaac_pkg;
    localparam int N_CELL = 14;
    localparam int N_AUX = 6;
    localparam int N_CHAN = N_CELL + 1 + N_AUX;
    localparam int STACK_IDX = N_CELL;
    localparam int CODE_W = 12;
    localparam int RES_W = 14;
    localparam int OVS_COUNT = 4;

    localparam logic [7:0] ADDR_MEAS_A = 8'h00;
    localparam logic [7:0] ADDR_MEAS_B = 8'h04;
    localparam logic [7:0] ADDR_SCAN = 8'h08;
    localparam logic [7:0] ADDR_POLARITY = 8'h0C;
    localparam logic [7:0] ADDR_AUX_REF = 8'h10;
    localparam logic [7:0] ADDR_AUX_PORT = 8'h14;
    localparam logic [7:0] ADDR_ACQ_CFG = 8'h18;
    localparam logic [7:0] ADDR_PACK = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_RESULT0 = 8'h40;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h90;

    localparam int MEAS_A_STACK_BIT = 14;
    localparam int SCAN_START_BIT = 0;
    localparam int SCAN_PATH_BIT = 1;
    localparam int SCAN_BUSY_BIT = 2;
    localparam int PACK_FLEX_BIT = 4;
    localparam int PACK_BLOCK_LSB = 8;
    localparam int STATUS_ALERT_BIT = 0;
    localparam int STATUS_RST_FLAG_BIT = 1;

    localparam logic [1:0] BIAS_MODE_OFF = 2'h2;
    localparam logic [1:0] BIAS_MODE_ON = 2'h3;
    localparam logic [3:0] TOP_CELL_OFF = 4'h0;
    localparam logic [3:0] TOP_CELL_MAX_BAD = 4'h7;
    localparam logic [3:0] TOP_POS_DEFAULT = 4'hF;
    localparam logic [1:0] BIAS_MODE_RESET = 2'h0;
endpackage : cbaac_pkg

// ---- tb/cbaac_checker.sv ----
/* Checker for the port behaviour of cbaac_top.
   Assumes it is bound to cbaac_top and sees the same APB writes as the design. */
`timescale 1ns/10ps
module cbaac_checker
    import cbaac_pkg::*;
(
    // Clock, reset and APB requests.
    input wire logic mclk, resetn, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Observed outputs.
    input wire logic conv_start, stack_divider_close, bias_output_pin_en, acq_busy,
    input wire logic supply_mux_fault_alert,
    input wire logic [4:0] conv_channel,
    input wire logic [N_AUX-1:0] aux_io_mode,
    input wire logic [3:0] supply_input_mux_sel
);
    logic [1:0] mode_q;
    logic [14:0] en_q;
    logic clr_q;
    wire logic wr = psel && penable && pwrite;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= 2'h0;
            en_q <= 15'h0;
            clr_q <= 1'h0;
        end else if (wr) begin
            if (paddr == ADDR_ACQ_CFG) mode_q <= pwdata[1:0];
            if (paddr == ADDR_MEAS_A) en_q <= pwdata[14:0];
            if (paddr == ADDR_STATUS && pwdata[STATUS_RST_FLAG_BIT]) clr_q <= 1'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_cell_req; conv_start && conv_channel < 5'h0E; endsequence
    sequence s_aux_req; conv_start && conv_channel > 5'h0E; endsequence
    property p_en; s_cell_req |-> en_q[conv_channel[3:0]]; endproperty
    a_en: assert property (p_en) else $error("disabled cell converted");
    property p_io; s_aux_req |-> !aux_io_mode[conv_channel - 5'h0F]; endproperty
    a_io: assert property (p_io) else $error("io port converted");
    property p_div; stack_divider_close |-> acq_busy; endproperty
    a_div: assert property (p_div) else $error("divider closed while idle");
    property p_div_on; acq_busy && en_q[MEAS_A_STACK_BIT] |-> stack_divider_close; endproperty
    a_div_on: assert property (p_div_on) else $error("divider open in stack scan");
    property p_auto; !mode_q[1] |-> bias_output_pin_en == acq_busy; endproperty
    a_auto: assert property (p_auto) else $error("bias auto mismatch");
    property p_on; mode_q == 2'h3 |-> bias_output_pin_en; endproperty
    a_on: assert property (p_on) else $error("bias not on");
    property p_off; mode_q == 2'h2 |-> !bias_output_pin_en; endproperty
    a_off: assert property (p_off) else $error("bias not off");
    property p_sel; supply_input_mux_sel inside {4'h0, [4'h8:4'hE]}; endproperty
    a_sel: assert property (p_sel) else $error("bad top cell position");
    property p_gate; !clr_q |-> !supply_mux_fault_alert; endproperty
    a_gate: assert property (p_gate) else $error("alert not gated");
endmodule : cbaac_checker

// ---- tb/cbaac_engine.sv ----
/* Conversion engine model that answers each start with one done pulse.
   Assumes request flags stay stable from start until done. */
`timescale 1ns/10ps
module cbaac_engine (
    // Clock, reset and pacing.
    input wire logic mclk, resetn, slow,
    // Conversion request.
    input wire logic conv_start, conv_alt_path, conv_bipolar, conv_ratiometric,
    input wire logic [4:0] conv_channel,
    // Conversion answer.
    output logic conv_done,
    output logic [11:0] conv_code
);
    int cnt = 0;
    initial conv_done = 1'h0;
    initial conv_code = 12'h5A5;
    always @(posedge mclk or negedge resetn) begin
        conv_done <= 1'h0;
        conv_code <= ~conv_code;
        if (!resetn) cnt <= 0;
        else if (conv_start) cnt <= slow ? 7 : 1;
        else if (cnt > 1) cnt <= cnt - 1;
        else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'h1;
            // The code echoes the request flags and channel.
            conv_code <= {conv_bipolar, conv_alt_path, conv_ratiometric, 4'h0, conv_channel};
        end
    end
endmodule : cbaac_engine

// ---- tb/cbaac_bench.sv ----
/* Bench for cbaac_top: APB tasks drive scans, pin modes and alerts.
   Assumes the engine model answers conversions and the checker is bound below. */
`timescale 1ns/10ps
module cbaac_bench
    import cbaac_pkg::*;
;
    logic mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic supply_mux_fault_raw = 1'h0, slow = 1'h0, pready, pslverr, err, conv_start;
    logic conv_alt_path, conv_bipolar, conv_ratiometric, conv_done, stack_divider_close;
    logic bias_output_pin_en, supply_input_mux_en, acq_busy, supply_mux_fault_alert;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [31:0] want [21];
    logic [11:0] conv_code;
    logic [4:0] conv_channel;
    logic [5:0] aux_io_mode;
    logic [3:0] supply_input_mux_sel, top_block_sel;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    always #50 mclk = ~mclk;
    cbaac_top cbaac_top_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .conv_start, .conv_channel, .conv_alt_path, .conv_bipolar,
        .conv_ratiometric, .conv_done, .conv_code, .stack_divider_close, .bias_output_pin_en,
        .aux_io_mode, .supply_input_mux_sel, .supply_input_mux_en, .top_block_sel, .acq_busy,
        .supply_mux_fault_raw, .supply_mux_fault_alert);
    cbaac_engine cbaac_engine_inst (.mclk, .resetn, .slow, .conv_start, .conv_alt_path,
        .conv_bipolar, .conv_ratiometric, .conv_channel, .conv_done, .conv_code);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
    task automatic scan(input logic [31:0] d);
        xfer(ADDR_SCAN, 1'h1, d);
        do xfer(ADDR_SCAN, 1'h0, 32'h0); while (rd[SCAN_BUSY_BIT] !== 1'h0);
    endtask : scan
    task automatic results;
        for (int i = 0; i < 21; i++) begin
            xfer(ADDR_RESULT0 + 8'(4 * i), 1'h0, 32'h0);
            check(rd, want[i]);
        end
    endtask : results
    function automatic logic [31:0] rw(input logic [2:0] f, input int c);
        return {16'h0, f, 4'h0, 5'(c), 4'h0};
    endfunction : rw
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        foreach (want[i]) want[i] = 32'h0;
        repeat (5) @(posedge mclk);
        resetn <= 1'h1;
        xfer(ADDR_PACK, 1'h0, 32'h0);
        check(rd, 32'hF10);
        xfer(ADDR_STATUS, 1'h0, 32'h0);
        check(rd, 32'h2);
        check(supply_input_mux_sel, 4'h0);
        check(top_block_sel, 4'hF);
        xfer(8'h30, 1'h1, 32'h1);
        check(err, 1'h1);
        results();
        $display("test reset done");
        xfer(ADDR_PACK, 1'h1, 32'hF1E);
        xfer(ADDR_POLARITY, 1'h1, 32'h4);
        xfer(ADDR_AUX_REF, 1'h1, 32'h1);
        xfer(ADDR_AUX_PORT, 1'h1, 32'h2);
        xfer(ADDR_MEAS_B, 1'h1, 32'h3);
        xfer(ADDR_MEAS_A, 1'h1, 32'h4005);
        check(supply_input_mux_sel, 4'hE);
        check(supply_input_mux_en, 1'h1);
        check(aux_io_mode, 6'h02);
        xfer(ADDR_MEAS_A, 1'h0, 32'h0);
        check(rd, 32'h4005);
        slow <= 1'h1;
        scan(32'h1);
        want[0] = rw(3'h0, 0);
        want[2] = rw(3'h4, 2);
        want[14] = rw(3'h0, 14);
        want[15] = rw(3'h1, 15);
        results();
        check(stack_divider_close, 1'h0);
        $display("test first scan done");
        xfer(ADDR_MEAS_B, 1'h1, 32'h0);
        xfer(ADDR_MEAS_A, 1'h1, 32'h2000);
        slow <= 1'h0;
        scan(32'h3);
        want[13] = rw(3'h2, 13);
        results();
        $display("test second scan done");
        for (int m = 0; m < 4; m++) begin
            xfer(ADDR_ACQ_CFG, 1'h1, 32'(m));
            @(posedge mclk);
            check(bias_output_pin_en, 32'(m == 3));
        end
        $display("test bias modes done");
        xfer(ADDR_PACK, 1'h1, 32'h315);
        @(posedge mclk);
        check(supply_input_mux_sel, 4'h0);
        check(supply_input_mux_en, 1'h0);
        check(top_block_sel, 4'hF);
        xfer(ADDR_PACK, 1'h1, 32'hC1E);
        @(posedge mclk);
        check(supply_input_mux_sel, 4'hE);
        check(supply_input_mux_en, 1'h1);
        check(top_block_sel, 4'hC);
        $display("test pack select done");
        supply_mux_fault_raw <= 1'h1;
        repeat (6) @(posedge mclk);
        check(supply_mux_fault_alert, 1'h0);
        xfer(ADDR_STATUS, 1'h1, 32'h2);
        repeat (4) @(posedge mclk);
        check(supply_mux_fault_alert, 1'h1);
        xfer(ADDR_STATUS, 1'h0, 32'h0);
        check(rd, 32'h1);
        supply_mux_fault_raw <= 1'h0;
        repeat (4) @(posedge mclk);
        check(supply_mux_fault_alert, 1'h0);
        $display("test alert done");
        conclude();
    end
endmodule : cbaac_bench
bind cbaac_top cbaac_checker cbaac_checker_inst (.mclk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .conv_start, .stack_divider_close, .bias_output_pin_en, .acq_busy,
    .supply_mux_fault_alert, .conv_channel, .aux_io_mode, .supply_input_mux_sel);
